/* File: cws_pkg.sv */
/*
 * cws_pkg: register map, fields, reset values and mode codes.
 * assumes: 32-bit AXI4-Lite bus, byte addresses, a word per register.
 */
package cws_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] CWS_OFF_CTRL0    = 8'h00; // waveform_control_0
    localparam logic [7:0] CWS_OFF_POL      = 8'h04; // output_polarity_control
    localparam logic [7:0] CWS_OFF_SHDN     = 8'h08; // shutdown_control
    localparam logic [7:0] CWS_OFF_SHSEL    = 8'h0c; // shutdown_source_select
    localparam logic [7:0] CWS_OFF_CTRL2    = 8'h10; // waveform_control_2 (restart enable)
    localparam logic [7:0] CWS_OFF_DBR      = 8'h14; // rising_deadband_count
    localparam logic [7:0] CWS_OFF_DBF      = 8'h18; // falling_deadband_count

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CWS_BIT_EN       = 7;
    localparam int CWS_BIT_LOAD     = 6;
    localparam int CWS_BIT_IN       = 5;
    localparam int CWS_BIT_SHDN     = 7;
    localparam int CWS_BIT_REN      = 6;
    localparam int CWS_POS_LVL_BD   = 4;
    localparam int CWS_POS_LVL_AC   = 2;
    localparam int CWS_BIT_CTRL2_REN = 0;

    // ****************************************************************
    // widths and reset values
    // ****************************************************************
    localparam int          CWS_NUM_SRC     = 4;
    localparam int          CWS_DB_W        = 6;
    localparam logic [2:0]  CWS_MODE_RST    = 3'h0;
    localparam logic [3:0]  CWS_POL_RST     = 4'h0;
    localparam logic [1:0]  CWS_LVL_RST     = 2'h0;
    localparam logic [3:0]  CWS_SHSEL_RST   = 4'h0;
    localparam logic [5:0]  CWS_DB_RST      = 6'h00;
    localparam logic [1:0]  CWS_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  CWS_RESP_SLVERR = 2'b10;

    // mode codes of the three-bit mode field
    localparam logic [2:0] CWS_MODE_STEER   = 3'h0;
    localparam logic [2:0] CWS_MODE_SSTEER  = 3'h1;
    localparam logic [2:0] CWS_MODE_FWD     = 3'h2;
    localparam logic [2:0] CWS_MODE_REV     = 3'h3;
    localparam logic [2:0] CWS_MODE_HALF    = 3'h4;
    localparam logic [2:0] CWS_MODE_PUSH    = 3'h5;

    typedef enum logic [1:0] {
        CWS_ST_OFF,
        CWS_ST_SHUT,
        CWS_ST_WAIT,
        CWS_ST_RUN
    } cws_state_e;

endpackage

/* File: cws_sync.sv */
/*
 * cws_sync: two flip-flop synchroniser for level inputs.
 * assumes: asynchronous levels; output two clk edges late.
 */
`timescale 1ns/1ps
module cws_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

/* File: cws_wave.sv */
/*
 * cws_wave: per-mode waveform of outputs a..d before polarity and
 * override; no dead-band timing. assumes: inp is synchronised.
 */
`timescale 1ns/1ps
module cws_wave
    import cws_pkg::*;
(
    // mode and input
    input  wire logic [2:0] mode,
    input  wire logic       inp,
    // raw outputs d,c,b,a
    output logic      [3:0] raw
);
    // full bridge: a/c steady, b/d modulated by direction
    always_comb begin
        case (mode)
            CWS_MODE_STEER,
            CWS_MODE_SSTEER: raw = {4{inp}};
            CWS_MODE_FWD:    raw = {inp, 1'b0, 1'b0, 1'b1};
            CWS_MODE_REV:    raw = {1'b0, 1'b1, inp, 1'b0};
            CWS_MODE_HALF,
            CWS_MODE_PUSH:   raw = {~inp, inp, ~inp, inp};
            default:         raw = 4'h0; // reserved codes drive low
        endcase
    end
endmodule

/* File: cws_top.sv */
/*
 * cws_top: shutdown override and restart control of a complementary
 * waveform generator behind an AXI4-Lite slave.
 * assumes: pins are asynchronous; pin direction lives outside.
 */
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
// Overview of operation
// [RULE1] clear enable before changing configuration
// [RULE2] pins stay inputs until enabled
// [RULE3] start from shutdown; program override levels
// [RULE4] set shutdown, clear restart before enabling
// [RULE5] start by restart enable or clearing shutdown
// [RULE6] override fields drive b/d and a/c
// [RULE7] overrides bypass polarity
// [RULE8] software clear fails while input active
// [RULE9] overrides hold until next input rise
// [RULE10] auto restart clears shutdown when inputs low; the code clears it once no selected shutdown input is low
// [RULE11] one restart enable selects restart method
// [RULE12] control 0 bit 7 enables generator
// [RULE13] load request loads dead-band at input event
// [RULE14] load request settable only when already enabled
// [RULE15] mode field decodes six modes, two reserved
// [RULE16] control 1 bit 5 reads input level
// [RULE17] control 1 bits 3..0 invert d..a
// [RULE18] shutdown inputs active low, level sensitive
// [RULE19] software shutdown applies overrides immediately
// [RULE20] active shutdown input sets shutdown bit
`timescale 1ns/1ps
module cws_top
    import cws_pkg::*;
#(
    parameter int NSRC = CWS_NUM_SRC,
    parameter int DBW  = CWS_DB_W
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    // axi4-lite write address
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    // axi4-lite write response
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    // axi4-lite read data
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // generator pins
    input  wire logic            wave_in,
    input  wire logic [NSRC-1:0] shutdown_n,
    output logic                 output_a,
    output logic                 output_b,
    output logic                 output_c,
    output logic                 output_d,
    // dead-band values as used by the timing logic
    output logic [DBW-1:0]       rising_deadband_count,
    output logic [DBW-1:0]       falling_deadband_count
);
    import cws_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic             en_reg;
    logic             load_reg;
    logic [2:0]       mode_reg;
    logic [3:0]       pol_reg;
    logic             shdn_reg;
    logic             ren_reg;
    logic [1:0]       lvl_bd_reg;
    logic [1:0]       lvl_ac_reg;
    logic [NSRC-1:0]  shsel_reg;
    logic [DBW-1:0]   dbr_reg;
    logic [DBW-1:0]   dbf_reg;
    logic             in_d_reg;
    cws_state_e       state_reg;
    cws_state_e       state_next;
    logic [3:0]       out_reg;
    logic [DBW-1:0]   dbr_act_reg;
    logic [DBW-1:0]   dbf_act_reg;

    // bus latches
    logic             aw_got_reg;
    logic             w_got_reg;
    logic [7:0]       awaddr_reg;
    logic [31:0]      wdata_reg;
    logic [3:0]       wstrb_reg;

    // ****************************************************************
    // synchronised pins
    // ****************************************************************
    logic             in_s;
    logic [NSRC-1:0]  sd_n_s;

    cws_sync #(.W(NSRC + 1)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({wave_in, shutdown_n}),
        .q      ({in_s, sd_n_s})
    );

    // ****************************************************************
    // input events and shutdown sources
    // ****************************************************************
    wire in_rise   = in_s & ~in_d_reg;
    wire in_fall   = ~in_s & in_d_reg;
    // active-low, level sensitive, only selected sources count
    wire sd_active = |(~sd_n_s & shsel_reg); // [RULE18]

    // ****************************************************************
    // write decode
    // ****************************************************************
    wire        wr_go    = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    wire        wr_ok    = wr_go & wstrb_reg[0];
    wire [7:0]  wb       = wdata_reg[7:0];
    wire        wr_ctrl0 = wr_ok & (awaddr_reg == CWS_OFF_CTRL0);
    wire        wr_pol   = wr_ok & (awaddr_reg == CWS_OFF_POL);
    wire        wr_shdn  = wr_ok & (awaddr_reg == CWS_OFF_SHDN);
    wire        wr_shsel = wr_ok & (awaddr_reg == CWS_OFF_SHSEL);
    wire        wr_ctrl2 = wr_ok & (awaddr_reg == CWS_OFF_CTRL2);
    wire        wr_dbr   = wr_ok & (awaddr_reg == CWS_OFF_DBR);
    wire        wr_dbf   = wr_ok & (awaddr_reg == CWS_OFF_DBF);
    wire        wr_hit   = (awaddr_reg[7:2] <= CWS_OFF_DBF[7:2]) & (awaddr_reg[1:0] == 2'b00);

    // restart enable lives in two views of one bit
    wire        ren_wr_v = wr_shdn ? wb[CWS_BIT_REN] : wb[CWS_BIT_CTRL2_REN];
    wire        ren_wr   = wr_shdn | wr_ctrl2; // [RULE11]
    wire        ren_next = ren_wr ? ren_wr_v : ren_reg;

    // load request only sets when enable was already 1 before this write
    wire        load_set = wr_ctrl0 & wb[CWS_BIT_LOAD] & en_reg; // [RULE14]
    wire        load_done = load_reg & (in_rise | in_fall); // [RULE13]

    // shutdown bit: hardware set wins over any software clear
    wire        sw_shdn_set = wr_shdn & wb[CWS_BIT_SHDN]; // [RULE19]
    wire        sw_shdn_clr = wr_shdn & ~wb[CWS_BIT_SHDN] & ~sd_active; // [RULE8]
    wire        auto_clr    = ren_next & ~sd_active; // [RULE10]
    wire        shdn_next   = sd_active | sw_shdn_set | // [RULE20]
                              (shdn_reg & ~sw_shdn_clr & ~auto_clr); // [RULE5]

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            en_reg     <= 1'b0; // [RULE12]
            mode_reg   <= CWS_MODE_RST;
            pol_reg    <= CWS_POL_RST;
            lvl_bd_reg <= CWS_LVL_RST;
            lvl_ac_reg <= CWS_LVL_RST;
            shsel_reg  <= CWS_SHSEL_RST;
        end else begin
            if (wr_ctrl0) begin
                en_reg   <= wb[CWS_BIT_EN]; // [RULE12]
                mode_reg <= wb[2:0]; // [RULE15]
            end
            if (wr_pol)
                pol_reg <= wb[3:0]; // [RULE17]
            if (wr_shdn) begin
                lvl_bd_reg <= wb[CWS_POS_LVL_BD +: 2]; // [RULE6]
                lvl_ac_reg <= wb[CWS_POS_LVL_AC +: 2];
            end
            if (wr_shsel)
                shsel_reg <= wb[NSRC-1:0];
        end
    end

    // shutdown, restart and load request flags
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shdn_reg <= 1'b0;
            ren_reg  <= 1'b0;
            load_reg <= 1'b0;
        end else begin
            shdn_reg <= shdn_next;
            ren_reg  <= ren_next;
            load_reg <= load_set | (load_reg & ~load_done & en_reg); // set wins
        end
    end

    // dead-band buffers: direct while disabled, on load request otherwise
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dbr_reg     <= CWS_DB_RST;
            dbf_reg     <= CWS_DB_RST;
            dbr_act_reg <= CWS_DB_RST;
            dbf_act_reg <= CWS_DB_RST;
        end else begin
            if (wr_dbr)
                dbr_reg <= wb[DBW-1:0];
            if (wr_dbf)
                dbf_reg <= wb[DBW-1:0];
            if (!en_reg || load_done) begin
                dbr_act_reg <= dbr_reg; // [RULE13]
                dbf_act_reg <= dbf_reg;
            end
        end
    end

    // ****************************************************************
    // generator state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CWS_ST_OFF:  if (en_reg) state_next = CWS_ST_SHUT; // [RULE3]
            CWS_ST_SHUT: if (!shdn_next) state_next = CWS_ST_WAIT;
            CWS_ST_WAIT: if (shdn_next) state_next = CWS_ST_SHUT;
                         else if (in_rise) state_next = CWS_ST_RUN; // [RULE9]
            CWS_ST_RUN:  if (shdn_next) state_next = CWS_ST_SHUT; // [RULE19]
            default:     state_next = CWS_ST_OFF;
        endcase
        if (!en_reg)
            state_next = CWS_ST_OFF;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= CWS_ST_OFF;
            in_d_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            in_d_reg  <= in_s;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    logic [3:0] raw;

    cws_wave u_wave (
        .mode (mode_reg),
        .inp  (in_s),
        .raw  (raw)
    );

    // override order d,c,b,a; polarity never touches override levels
    wire [3:0] ovr      = {lvl_bd_reg[1], lvl_ac_reg[1], lvl_bd_reg[0], lvl_ac_reg[0]}; // [RULE6]
    wire       hold_ovr = (state_next == CWS_ST_SHUT) | (state_next == CWS_ST_WAIT);
    wire [3:0] out_next = (state_next == CWS_ST_OFF) ? 4'h0 :
                          hold_ovr ? ovr : (raw ^ pol_reg); // [RULE7]

    always_ff @(posedge clk) begin
        if (!resetn) begin
            out_reg <= 4'h0;
        end else begin
            out_reg <= out_next; // [RULE9]
        end
    end

    assign output_a               = out_reg[0];
    assign output_b               = out_reg[1];
    assign output_c               = out_reg[2];
    assign output_d               = out_reg[3];
    assign rising_deadband_count  = dbr_act_reg;
    assign falling_deadband_count = dbf_act_reg;

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    // address and data taken in either order, response after both
    always_ff @(posedge clk) begin
        if (!resetn) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= CWS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? CWS_RESP_OKAY : CWS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = resetn & ~aw_got_reg & ~s_axi_bvalid;
    assign s_axi_wready  = resetn & ~w_got_reg & ~s_axi_bvalid;

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    wire [7:0] ra = s_axi_araddr;
    logic [7:0] rd_byte;
    logic       rd_hit;

    // unimplemented bits read as zero
    always_comb begin
        rd_hit  = (ra[1:0] == 2'b00);
        rd_byte = 8'h00;
        case (ra)
            CWS_OFF_CTRL0: rd_byte = {en_reg, load_reg, 3'b000, mode_reg};
            CWS_OFF_POL:   rd_byte = {2'b00, in_s, 1'b0, pol_reg}; // [RULE16]
            CWS_OFF_SHDN:  rd_byte = {shdn_reg, ren_reg, lvl_bd_reg, lvl_ac_reg, 2'b00};
            CWS_OFF_SHSEL: rd_byte = 8'(shsel_reg);
            CWS_OFF_CTRL2: rd_byte = {7'h00, ren_reg};
            CWS_OFF_DBR:   rd_byte = 8'(dbr_reg);
            CWS_OFF_DBF:   rd_byte = 8'(dbf_reg);
            default:       rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= CWS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= rd_hit ? CWS_RESP_OKAY : CWS_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = resetn & ~s_axi_rvalid;
endmodule

/* File: cws_monitor.sv */
/*
 * cws_monitor: concurrent checks on the ports of cws_top.
 * assumes: one clock domain, synchronous active-low reset, bound by name.
 */
`timescale 1ns/1ps
module cws_monitor
    import cws_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // generator outputs
    input wire logic        output_a,
    input wire logic        output_b,
    input wire logic        output_c,
    input wire logic        output_d
);
    // ****************************************************************
    // bus handshakes
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_at(logic [7:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_busy_refuse: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        and (s_axi_rvalid |-> !s_axi_arready)) else $error("request taken while busy");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr > 8'h18 || s_axi_araddr[1:0] != 2'h0) |=>
        s_axi_rresp == CWS_RESP_SLVERR) else $error("unmapped read not refused");
    // ****************************************************************
    // register contents and outputs
    // ****************************************************************
    a_ctrl_unused: assert property (s_rd_at(CWS_OFF_CTRL0) |=> s_axi_rdata[31:8] == 24'h0 &&
        s_axi_rdata[5:3] == 3'h0) else $error("control 0 spare bits set");
    a_pol_unused: assert property (s_rd_at(CWS_OFF_POL) |=> s_axi_rdata[31:6] == 26'h0 &&
        !s_axi_rdata[4]) else $error("polarity spare bits set");
    a_reset_quiet: assert property ($rose(resetn) |-> !output_a && !output_b &&
        !output_c && !output_d) else $error("outputs active after reset");
endmodule
bind cws_top cws_monitor mon_u (.*);

/* File: cws_bridge_model.sv */
/*
 * cws_bridge_model: bridge drivers giving the input wave and
 * active-low fault lines. assumes: bench commands at clock edges.
 */
`timescale 1ns/1ps
module cws_bridge_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // commands from the bench
    input  wire logic       wv,
    input  wire logic [3:0] flt,
    // pins into the block
    output logic            wave_in,
    output logic [3:0]      shutdown_n
);
    // fault lines idle high, as if pulled up
    initial begin
        wave_in    = 1'b0;
        shutdown_n = 4'hf;
    end
    // pins change a clock late, registered on the same clk as the block
    always @(posedge clk) begin
        wave_in    <= wv && resetn;
        shutdown_n <= ~flt | {4{!resetn}};
    end
endmodule

/* File: testbench.sv */
/*
 * testbench: self-checking run of cws_top over its register bus
 * and bridge model. assumes: 250 MHz clock, seed 50.
 */
`timescale 1ns/1ps
module testbench;
    import cws_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rq;
    logic [3:0]  s_axi_wstrb, shutdown_n, flt, pol, outs, o1;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        wave_in, output_a, output_b, output_c, output_d, wv;
    logic [5:0]  rising_deadband_count, falling_deadband_count, r6;
    logic [7:0]  lv, md;
    int          mismatches = 0;
    int          total_checks = 0;
    int unsigned seed;
    assign outs = {output_d, output_c, output_b, output_a};
    cws_top dut_u (.*);
    cws_bridge_model bridge_u (.*);
    always #2 clk = ~clk;
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // override levels {d,c,b,a} of a shutdown_control value
    function automatic logic [3:0] ovr(input logic [7:0] s);
        return {s[5], s[3], s[4], s[2]};
    endfunction
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pins(input logic w, input logic [3:0] f);
        wv <= w;
        flt <= f;
        wt(8);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(0, a, 0);
        chk(nm, rq, e);
    endtask
    // outputs sampled mid-cycle
    task automatic chko(input string nm, input logic [3:0] e);
        @(negedge clk);
        chk(nm, outs, e);
        @(posedge clk);
    endtask
    // one bus transfer, released after the taking edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int  n;
        logic done, ta, tw, tr;
        done = 1'b0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid  <= w;
        s_axi_bready  <= w;
        s_axi_arvalid <= !w;
        s_axi_rready  <= !w;
        for (n = 0; n < 40 && !done; n++) begin
            @(negedge clk);
            done = w ? s_axi_bvalid : s_axi_rvalid;
            rq = s_axi_rdata;
            rr = w ? s_axi_bresp : s_axi_rresp;
            ta = s_axi_awready;
            tw = s_axi_wready;
            tr = s_axi_arready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
            if (done) begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end
        end
        if (!done) begin
            mismatches++;
            end_sim();
        end
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
        wv = 1'b0;
        flt = 4'h0;
        wt(12);
        resetn <= 1'b1;
        seed = $urandom(50);
        for (int i = 0; i < 7; i++)
            rd("reset value", 8'(i * 4), 0);
        xfer(0, 8'h1c, 0);
        chk("unmapped read", rr, CWS_RESP_SLVERR);
        xfer(1, 8'h02, 32'hff);
        chk("unaligned write", rr, CWS_RESP_SLVERR);
        md = 8'($urandom_range(5));
        lv = 8'($urandom) & 8'h3c;
        pol = 4'($urandom);
        xfer(1, CWS_OFF_CTRL0, md);
        xfer(1, CWS_OFF_SHSEL, 4'h3);
        xfer(1, CWS_OFF_SHDN, 8'h80 | lv);
        xfer(1, CWS_OFF_POL, pol);
        wt(6);
        chko("disabled outs", 0);
        // load request in the enabling write must be dropped
        xfer(1, CWS_OFF_CTRL0, 8'hc0 | md);
        rd("enable write", CWS_OFF_CTRL0, 8'h80 | md);
        wt(6);
        chko("start overrides", ovr(lv));
        xfer(1, CWS_OFF_DBR, 6'h2a);
        xfer(1, CWS_OFF_CTRL0, 8'hc0 | md);
        rd("load pending", CWS_OFF_CTRL0, 8'hc0 | md);
        chk("buffered rise", rising_deadband_count, 0);
        pins(1, 4'h0);
        rd("load done", CWS_OFF_CTRL0, 8'h80 | md);
        chk("loaded rise", rising_deadband_count, 6'h2a);
        rd("input level", CWS_OFF_POL, 8'h20 | pol);
        // software clear refused while a selected fault stands
        pins(1, 4'h1);
        xfer(1, CWS_OFF_SHDN, lv);
        rd("clear refused", CWS_OFF_SHDN, 8'h80 | lv);
        pins(1, 4'h4);
        xfer(1, CWS_OFF_SHDN, lv);
        rd("clear taken", CWS_OFF_SHDN, lv);
        wt(6);
        chko("hold till rise", ovr(lv));
        pins(0, 4'h4);
        chko("hold on fall", ovr(lv));
        pins(1, 4'h4);
        @(negedge clk);
        o1 = outs;
        xfer(1, CWS_OFF_POL, ~pol);
        wt(6);
        chko("polarity flip", o1 ^ 4'hf);
        pins(1, 4'h6);
        chko("fault overrides", ovr(lv));
        rd("fault sets bit", CWS_OFF_SHDN, 8'h80 | lv);
        // automatic restart once the selected fault goes away
        xfer(1, CWS_OFF_SHDN, 8'hc0 | lv);
        rd("restart view", CWS_OFF_CTRL2, 1);
        rd("fault holds", CWS_OFF_SHDN, 8'hc0 | lv);
        pins(1, 4'h4);
        rd("auto clear", CWS_OFF_SHDN, 8'h40 | lv);
        chko("auto hold", ovr(lv));
        pins(0, 4'h4);
        pins(1, 4'h4);
        chko("auto resume", o1 ^ 4'hf);
        xfer(1, CWS_OFF_CTRL2, 0);
        rd("restart off", CWS_OFF_SHDN, lv);
        xfer(1, CWS_OFF_SHDN, 8'h80 | lv);
        wt(2);
        chko("soft shutdown", ovr(lv));
        xfer(1, CWS_OFF_CTRL0, md);
        wt(2);
        chko("disable outs", 0);
        r6 = 6'($urandom);
        xfer(1, CWS_OFF_DBF, r6);
        wt(2);
        chk("direct fall", falling_deadband_count, r6);
        for (int m = 0; m < 8; m++) begin
            xfer(1, CWS_OFF_CTRL0, m);
            rd("mode field", CWS_OFF_CTRL0, m);
        end
        for (int k = 0; k < 6; k++) begin
            pol = 4'($urandom);
            xfer(1, CWS_OFF_POL, ($urandom & 32'hffff_fff0) | pol);
            rd("polarity field", CWS_OFF_POL, 8'h20 | pol);
        end
        end_sim();
    end
endmodule
